// ### shared/utx_map.svh
// Functional notes
// - Frame is start, eight or nine data bits, stop: 10 or 11 bits long.
// - Ninth bit comes from ninth_tx_bit and stays until software rewrites it.
// - One 16-bit modulus counter loaded from baud_divisor makes all baud timing.
// - Divisor bits 15:4 give coarse division, bits 3:0 give fine adjust.
// - Baud clock is sixteen times bit rate; transmitter shifts every 16 ticks.
// - Without infrared, baud tick rate is bus clock over full divisor.
// - Divisor of zero disables the generator; no baud ticks at all.
// - Writing baud_div_high takes effect only when baud_div_low is written.
// - Shift register gets start bit 0 at bottom and stop bit 1 at top.
// - Buffer moves to shifter and empty flag sets 9/16 bit into stop bit.
// - Interrupt request while empty flag and its enable are both set.
// - Reset sets tx_buffer_empty_flag.
// - No new buffered frame starts until the empty flag has been cleared.
// - Rising tx_on sends a preamble of 10 or 11 ones, then buffered data.
// - Parity, odd or even, replaces the top data bit when enabled.
// - Output idles high with no frame (low in infrared mode); clearing tx_on idles the transmitter.
// - Clearing tx_on mid-frame lets the current frame finish first.
// - Toggling tx_on after the last load queues a preamble after that frame.
// - Infrared mode sends a pulse for each zero and nothing for each one.
// - Data register buffers the next character while the shifter sends.
// - Top data bit may be an address marker instead of parity.
// - Break sends all-zero characters while set, then idle ones or, if data waits, the next start bit at once.
`ifndef UTX_MAP_SVH
`define UTX_MAP_SVH
`define UTX_OFF_BAUD_HIGH  12'h000
`define UTX_OFF_BAUD_LOW   12'h004
`define UTX_OFF_CTRL_ONE   12'h008
`define UTX_OFF_CTRL_TWO   12'h00c
`define UTX_OFF_STATUS_ONE 12'h010
`define UTX_OFF_DATA_HIGH  12'h018
`define UTX_OFF_DATA_LOW   12'h01c
`define UTX_C1_PTYPE       0
`define UTX_C1_PEN         1
`define UTX_C1_NINE        4
`define UTX_C1_INFRARED_ENABLE        7
`define UTX_C2_BREAK       0
`define UTX_C2_TXON        3
`define UTX_C2_TIE         7
`define UTX_SR_TC          6
`define UTX_SR_TX_BUFFER_EMPTY_FLAG        7
`define UTX_DH_T8          6
`define UTX_BAUD_RESET     16'h0004
`define UTX_TICKS_PER_BIT  5'h10
`define UTX_LOAD_TICK      4'h9
`define UTX_FRAME_BITS_8   4'ha
`define UTX_FRAME_BITS_9   4'hb
`endif

// ### shared/utx_pkg.sv
package utx_pkg;
   typedef enum logic [1:0] {
      UTX_IDLE     = 2'b00,
      UTX_PREAMBLE = 2'b01,
      UTX_FRAME    = 2'b11,
      UTX_BREAK    = 2'b10
   } utx_state_t;
endpackage

// ### hdl/utx_baud_gen.sv
`include "utx_map.svh"
module utx_baud_gen (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Divisor
   input  wire logic [15:0] divisor,
   // Tick output
   output logic             tick
);
   import utx_pkg::*;

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   wire         running = (divisor != 16'h0000);
   // Coarse bits and fine bits together set a period of exactly divisor cycles.
   wire         at_end  = running && (cnt_q >= divisor - 16'h0001);

   assign cnt_d = (!running || at_end) ? 16'h0000 : cnt_q + 16'h0001;

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= at_end;
      end
   end
endmodule

// ### hdl/utx_top.sv
`include "utx_map.svh"
module utx_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial side
   output logic             txd,
   output logic             baud_tick,
   output logic             tx_irq
);
   import utx_pkg::*;

   utx_state_t  state_q;
   utx_state_t  state_d;
   logic [15:0] baud_q;
   logic [7:0]  baud_high_pend_q;
   logic [7:0]  ctrl_one_q;
   logic [7:0]  ctrl_two_q;
   logic [7:0]  data_low_q;
   logic        ninth_tx_bit_q;
   logic        tx_buffer_empty_flag_q;
   logic        tc_q;
   logic        armed_q;
   logic        pend_pre_q;
   logic        txon_prev_q;
   logic [11:0] shift_q;
   logic [3:0]  bits_left_q;
   logic [3:0]  sub_q;
   logic        ir_pulse_q;
   logic        txd_q;

   function automatic logic sel(input logic [11:0] off);
      sel = (paddr == off);
   endfunction

   wire        acc       = psel && penable;
   wire        wr        = acc && pwrite;
   wire        rd        = acc && !pwrite;
   wire        hit       = sel(`UTX_OFF_BAUD_HIGH) || sel(`UTX_OFF_BAUD_LOW) || sel(`UTX_OFF_CTRL_ONE)
                           || sel(`UTX_OFF_CTRL_TWO) || sel(`UTX_OFF_STATUS_ONE) || sel(`UTX_OFF_DATA_HIGH)
                           || sel(`UTX_OFF_DATA_LOW);
   wire        wr_bdh    = wr && sel(`UTX_OFF_BAUD_HIGH);
   wire        wr_bdl    = wr && sel(`UTX_OFF_BAUD_LOW);
   wire        wr_c1     = wr && sel(`UTX_OFF_CTRL_ONE);
   wire        wr_c2     = wr && sel(`UTX_OFF_CTRL_TWO);
   wire        wr_dh     = wr && sel(`UTX_OFF_DATA_HIGH);
   wire        wr_dl     = wr && sel(`UTX_OFF_DATA_LOW);
   wire        rd_sr     = rd && sel(`UTX_OFF_STATUS_ONE);

   wire        nine      = ctrl_one_q[`UTX_C1_NINE];
   wire        par_en    = ctrl_one_q[`UTX_C1_PEN];
   wire        par_odd   = ctrl_one_q[`UTX_C1_PTYPE];
   wire        ir_en     = ctrl_one_q[`UTX_C1_INFRARED_ENABLE];
   wire        tx_on     = ctrl_two_q[`UTX_C2_TXON];
   wire        brk       = ctrl_two_q[`UTX_C2_BREAK];
   wire        tx_empty_irq_enable       = ctrl_two_q[`UTX_C2_TIE];
   wire [3:0]  frame_len = nine ? `UTX_FRAME_BITS_9 : `UTX_FRAME_BITS_8;

   // Bit timing: each bit lasts 16 ticks, the last bit ends the frame.
   wire        tick      = baud_tick;
   wire        bit_end   = tick && (sub_q == 4'hf);
   wire        busy      = (state_q != UTX_IDLE);
   wire        last_bit  = busy && (bits_left_q == 4'h1);
   // The next load happens 9 ticks into the final bit, which for a frame is the stop bit.
   wire        load_pt   = last_bit && tick && (sub_q == (`UTX_LOAD_TICK - 4'h1));
   wire        data_rdy  = !tx_buffer_empty_flag_q;
   wire        rise_on   = tx_on && !txon_prev_q;
   // An idle shifter starts only on a baud tick, so every line change lines up with the bit grid.
   wire        idle_go   = !busy && tick;

   // Parity of the data bits that precede the parity position.
   wire        par_even  = nine ? ^{data_low_q} : ^{data_low_q[6:0]};
   wire        par_bit   = par_even ^ par_odd;
   wire [8:0]  payload   = nine ? {par_en ? par_bit : ninth_tx_bit_q, data_low_q}
                                : {1'b1, par_en ? par_bit : data_low_q[7], data_low_q[6:0]};
   // For eight-bit frames bit 9 is the stop bit and bit 10 is padding that never shifts out.
   wire [10:0] frame_w   = nine ? {1'b1, payload, 1'b0} : {1'b1, 1'b1, payload[7:0], 1'b0};

   // Decide what the shifter holds next when it is free or about to be.
   logic       start_pre;
   logic       start_brk;
   logic       start_dat;
   always_comb begin
      start_pre = 1'b0;
      start_brk = 1'b0;
      start_dat = 1'b0;
      state_d   = state_q;
      if (!busy || load_pt || (busy && bit_end && last_bit && !tx_on)) begin
         if (tx_on && (pend_pre_q || rise_on)) begin
            start_pre = idle_go || load_pt;
         end else if (tx_on && brk) begin
            start_brk = idle_go || load_pt;
         end else if (tx_on && data_rdy && armed_go_q) begin
            start_dat = idle_go || load_pt;
         end
      end
      if (start_pre) begin
         state_d = UTX_PREAMBLE;
      end else if (start_brk) begin
         state_d = UTX_BREAK;
      end else if (start_dat) begin
         state_d = UTX_FRAME;
      end else if (busy && bit_end && last_bit) begin
         state_d = UTX_IDLE;
      end
   end

   wire        load      = start_pre || start_brk || start_dat;
   wire [11:0] next_w    = start_dat ? {1'b1, frame_w} : (start_brk ? 12'h000 : 12'hfff);

   // A frame already in the shifter always completes, even after tx_on is cleared.
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q     <= UTX_IDLE;
         shift_q     <= 12'hfff;
         bits_left_q <= 4'h0;
         sub_q       <= 4'h0;
         txd_q       <= 1'b1;
      end else begin
         state_q <= state_d;
         if (load && busy) begin
            // The stop bit in flight keeps its full length; the new frame follows when it ends.
            shift_q     <= {next_w[10:0], 1'b1};
            bits_left_q <= frame_len + 4'h1;
            sub_q       <= sub_q + 4'h1;
         end else if (load) begin
            shift_q     <= next_w;
            bits_left_q <= frame_len;
            sub_q       <= 4'h0;
            txd_q       <= next_w[0];
         end else if (busy && tick) begin
            sub_q <= sub_q + 4'h1;
            if (bit_end) begin
               shift_q     <= {1'b1, shift_q[11:1]};
               bits_left_q <= bits_left_q - 4'h1;
               txd_q       <= last_bit ? 1'b1 : shift_q[1];
            end
         end else if (!busy) begin
            txd_q <= 1'b1;
         end
      end
   end

   // A zero bit gives a pulse in the middle of the bit, three ticks wide.
   always_ff @(posedge mclk) begin
      if (reset) begin
         ir_pulse_q <= 1'b0;
      end else begin
         ir_pulse_q <= busy && !txd_q && (sub_q >= 4'h7) && (sub_q <= 4'h9);
      end
   end
   assign txd = ir_en ? ir_pulse_q : txd_q;

   // Flags and control state.
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_buffer_empty_flag_q      <= 1'b1;
         tc_q        <= 1'b1;
         armed_q     <= 1'b0;
         pend_pre_q  <= 1'b0;
         txon_prev_q <= 1'b0;
      end else begin
         txon_prev_q <= tx_on;
         if (start_pre) begin
            pend_pre_q <= 1'b0;
         end else if (rise_on) begin
            pend_pre_q <= 1'b1;
         end
         // Setting the flag on a load outranks the clear from a data write in the same cycle.
         if (start_dat) begin
            tx_buffer_empty_flag_q <= 1'b1;
         end else if (wr_dl && armed_q) begin
            tx_buffer_empty_flag_q <= 1'b0;
         end
         if (start_dat || wr_dl) begin
            armed_q <= 1'b0;
         end else if (rd_sr && tx_buffer_empty_flag_q) begin
            armed_q <= 1'b1;
         end
         if (load) begin
            tc_q <= 1'b0;
         end else if (!busy) begin
            tc_q <= 1'b1;
         end
      end
   end

   // Armed marks the status read; a data write then arms the shifter.
   logic armed_go_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         armed_go_q <= 1'b0;
      end else begin
         armed_go_q <= (wr_dl && armed_q) ? 1'b1 : (start_dat ? 1'b0 : armed_go_q);
      end
   end

   // Registers written by software.
   always_ff @(posedge mclk) begin
      if (reset) begin
         baud_q           <= `UTX_BAUD_RESET;
         baud_high_pend_q <= 8'h00;
         ctrl_one_q       <= 8'h00;
         ctrl_two_q       <= 8'h00;
         data_low_q       <= 8'h00;
         ninth_tx_bit_q   <= 1'b0;
      end else begin
         if (wr_bdh) begin
            baud_high_pend_q <= pwdata[7:0];
         end
         if (wr_bdl) begin
            baud_q <= {baud_high_pend_q, pwdata[7:0]};
         end
         if (wr_c1) begin
            ctrl_one_q <= pwdata[7:0];
         end
         if (wr_c2) begin
            ctrl_two_q <= pwdata[7:0];
         end
         if (wr_dh) begin
            ninth_tx_bit_q <= pwdata[`UTX_DH_T8];
         end
         if (wr_dl) begin
            data_low_q <= pwdata[7:0];
         end
      end
   end

   // Read data is registered during the setup cycle so it meets the zero-wait answer.
   logic [7:0] rd_mux;
   assign rd_mux = sel(`UTX_OFF_BAUD_HIGH)  ? baud_q[15:8] :
                   sel(`UTX_OFF_BAUD_LOW)   ? baud_q[7:0] :
                   sel(`UTX_OFF_CTRL_ONE)   ? ctrl_one_q :
                   sel(`UTX_OFF_CTRL_TWO)   ? ctrl_two_q :
                   sel(`UTX_OFF_STATUS_ONE) ? {tx_buffer_empty_flag_q, tc_q, 6'h00} :
                   sel(`UTX_OFF_DATA_HIGH)  ? {1'b0, ninth_tx_bit_q, 6'h00} :
                   8'h00;

   logic ready_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         ready_q <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         ready_q <= psel && !penable;
         if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
         end
      end
   end
   assign pready  = ready_q;
   assign pslverr = pready && !hit;

   assign tx_irq = tx_buffer_empty_flag_q && tx_empty_irq_enable;

   utx_baud_gen u_baud (
      .mclk    (mclk),
      .reset   (reset),
      .divisor (baud_q),
      .tick    (baud_tick)
   );

endmodule

// ### verif/utx_chk.sv
`include "utx_map.svh"
module utx_chk (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial
   input wire logic        txd,
   input wire logic        baud_tick,
   input wire logic        tx_irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   AST_RDY_ACC: assert property (psel && !penable |=> pready) else $error("no ready");
   AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready held");
   AST_RDY_SEL: assert property (pready |-> psel && penable) else $error("stray ready");
   AST_ERR_RD: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("error read");
   AST_RD_HI: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("high bits");
   AST_TXD_TICK: assert property ($changed(txd) |-> $past(baud_tick)) else $error("txd off tick");
   AST_RST_IDLE: assert property ($fell(reset) |-> txd && !tx_irq) else $error("not idle");
   AST_IRQ_OFF: assert property (pready && pwrite && paddr == `UTX_OFF_CTRL_TWO
      && !pwdata[`UTX_C2_TIE] |=> !tx_irq) else $error("irq on");
   cover property (pslverr);
   cover property ($fell(txd));
   cover property (tx_irq);
endmodule

// ### verif/utx_rx_model.sv
module utx_rx_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // Line
   input  wire logic txd,
   input  wire logic baud_tick,
   input  wire logic nine,
   // Result
   output logic [8:0] rx_word,
   output logic       rx_valid,
   output logic       rx_start,
   output logic       rx_ferr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy;
   logic [8:0] sh;
   int         c;
   int         k;
   // Bits are read at their centre, so a shifter a tick early or late still decodes.
   always @(posedge mclk) begin
      rx_valid <= 1'b0;
      rx_start <= 1'b0;
      if (reset) begin
         busy <= 1'b0;
         rx_ferr <= 1'b0;
      end else if (baud_tick && !busy && txd === 1'b0) begin
         busy <= 1'b1;
         rx_start <= 1'b1;
         c = 1;
         sh = 9'h0;
      end else if (baud_tick && busy) begin
         c++;
         k = (c - 8) / 16;
         if (c % 16 == 8) begin
            if (k == 0) rx_ferr <= rx_ferr | txd;
            else if (k <= 8 + nine) sh[k - 1] = txd;
            else begin
               rx_word <= sh;
               rx_valid <= 1'b1;
               rx_ferr <= rx_ferr | !txd;
               busy <= 1'b0;
            end
         end
      end
   end
endmodule

// ### verif/uart_tx_baud_frame_tb.sv
`include "utx_map.svh"
module uart_tx_baud_frame_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, reset, psel, penable, pwrite, pready, pslverr, txd, baud_tick, tx_irq;
   logic        rx_valid, rx_start, rx_ferr, nine, err, t8;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [8:0]  rx_word, w, exp_q[$], got_q[$];
   logic [7:0]  p, cfg [5] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h13};
   int          n_fail, cmp_count, tk, g, n;
   utx_top u_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txd,
      .baud_tick, .tx_irq);
   utx_rx_model u_rx (.mclk, .reset, .txd, .baud_tick, .nine, .rx_word, .rx_valid, .rx_start, .rx_ferr);
   always #20 mclk = ~mclk;
   always @(posedge mclk) tk <= rx_start ? 1 : tk + int'(baud_tick);
   always @(posedge mclk) if (rx_valid) got_q.push_back(rx_word);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // Each call starts one edge late so a release and the next setup never share an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic tick_gap();
      n = 0;
      do @(posedge mclk); while (baud_tick !== 1'b1 && ++n < 300);
      g = 1;
      do @(posedge mclk); while (baud_tick !== 1'b1 && ++g < 300);
   endtask
   task automatic end_of_test();
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {mclk, psel, penable, pwrite, paddr, pwdata, nine, tk, n_fail, cmp_count} = '0;
      reset = 1'b1;
      seed = 32'hfa96;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, `UTX_OFF_STATUS_ONE, 32'h0);
      chk(rd[`UTX_SR_TX_BUFFER_EMPTY_FLAG] === 1'b1, "flag after reset");
      apb(1'b0, 12'h020, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped read");
      tick_gap();
      chk(g == 4, "reset divisor");
      apb(1'b1, `UTX_OFF_BAUD_HIGH, 32'h1);
      tick_gap();
      chk(g == 4, "high half alone");
      apb(1'b1, `UTX_OFF_BAUD_HIGH, 32'h0);
      apb(1'b1, `UTX_OFF_BAUD_LOW, 32'h0);
      tick_gap();
      chk(g == 300, "zero divisor");
      apb(1'b1, `UTX_OFF_BAUD_LOW, 32'h2);
      tick_gap();
      chk(g == 2, "divisor two");
      foreach (cfg[c]) begin
         p = cfg[c];
         nine <= p[4];
         apb(1'b1, `UTX_OFF_CTRL_ONE, {24'h0, p});
         for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            if (i == 0) t8 = seed[8];
            w = {p[4] & t8, seed[7:0]};
            if (p[1] && p[4]) w[8] = ^w[7:0] ^ p[0];
            if (p[1] && !p[4]) w[7] = ^w[6:0] ^ p[0];
            exp_q.push_back(w);
            if (i == 0) apb(1'b1, `UTX_OFF_DATA_HIGH, {25'h0, t8, 6'h0});
            n = 0;
            do apb(1'b0, `UTX_OFF_STATUS_ONE, 32'h0); while (rd[7] !== 1'b1 && ++n < 300);
            apb(1'b1, `UTX_OFF_DATA_LOW, {24'h0, seed[7:0]});
            if (i == 0) begin
               apb(1'b1, `UTX_OFF_CTRL_TWO, 32'h88);
               {g, n} = '0;
               while (rx_start !== 1'b1 && ++n < 2000) begin
                  @(posedge mclk);
                  g += int'(baud_tick);
               end
               chk(g >= 160 + 16 * p[4] && g <= 194 + 16 * p[4], "preamble");
            end else begin
               @(posedge mclk);
               chk(tx_irq === 1'b0, "irq while full");
               n = 0;
               while (tx_irq !== 1'b1 && ++n < 2000) @(posedge mclk);
               chk(tk >= 151 + 16 * p[4] && tk <= 155 + 16 * p[4], "load point");
            end
         end
         apb(1'b1, `UTX_OFF_CTRL_TWO, 32'h0);
         n = 0;
         while (got_q.size() < 3 && ++n < 4000) @(posedge mclk);
         foreach (exp_q[j]) chk(got_q.size() > j && got_q[j] === exp_q[j], "frame");
         g = 0;
         repeat (100) begin
            @(posedge mclk);
            g += int'(txd !== 1'b1);
         end
         chk(g == 0 && rx_ferr === 1'b0, "idle or framing");
         exp_q.delete();
         got_q.delete();
      end
      end_of_test();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
endmodule
bind utx_top utx_chk u_chk (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .txd, .baud_tick, .tx_irq);
